// file: ground_fault_loop_selector.sv
`timescale 1ns/1ns
`include "ground_fault_loop_selector_defs.svh"

// Notes on behaviour
// R01: Ground loops only when earlier stages idle
// R02: Start needs loop in zone and minimal
// R03: Minimum ground impedance is least of three
// R04: No start if another ground loop started
// R05: Start needs residual and phase current flags
// R06: Ground minimum below phase-pair minimum
// R07: Same conditions for phases two and three
// R08: Off setting or block input kills start and trip outputs
// R09: Per-phase starts for every involved phase
// R10: General start when any phase involved
// R11: Timer runs while started and trips wanted
// R12: Current unit gives per-phase and residual flags
// R13: Phase flag above clamped 10..30 percent setting
// R14: Residual threshold biased by phase currents
// R15: Start-only nonzero suppresses the trip
// R16: Trip delay 0..60000 ms in 1 ms steps
// R17: Residual above max of base and bias
// R18: Timer clears and trip drops when start drops
module ground_fault_loop_selector
   import ground_fault_loop_selector_pkg::*;
#(
   parameter logic [31:0] CYCLES_PER_MS = `CYCLES_PER_MS,
   parameter logic [15:0] RATED_CURRENT = `RATED_CURRENT_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Earlier sequential stages
   input wire logic three_phase_start_i,
   input wire logic phase_loop12_start_i,
   input wire logic phase_loop23_start_i,
   input wire logic phase_loop31_start_i,
   // Ground loop comparators
   input wire logic ground_loop1_in_zone_i,
   input wire logic ground_loop2_in_zone_i,
   input wire logic ground_loop3_in_zone_i,
   input wire logic [15:0] ground_loop1_impedance_i,
   input wire logic [15:0] ground_loop2_impedance_i,
   input wire logic [15:0] ground_loop3_impedance_i,
   input wire logic [15:0] min_phase_pair_impedance_i,
   // Current measurements
   input wire logic [15:0] phase1_current_i,
   input wire logic [15:0] phase2_current_i,
   input wire logic [15:0] phase3_current_i,
   input wire logic [15:0] residual_current_i,
   // Settings and block input
   input wire logic operation_off_setting_i,
   input wire logic block_input_i,
   input wire logic start_only_setting_i,
   input wire logic [15:0] trip_delay_setting_i,
   input wire logic [7:0] phase_current_min_setting_i,
   input wire logic [7:0] residual_base_setting_i,
   input wire logic [7:0] residual_bias_setting_i,
   // Loop starts
   output logic ground_loop1_start_o,
   output logic ground_loop2_start_o,
   output logic ground_loop3_start_o,
   // Phase and general starts, trip
   output logic phase1_start_out_o,
   output logic phase2_start_out_o,
   output logic phase3_start_out_o,
   output logic phase1_general_start_o,
   output logic phase2_general_start_o,
   output logic phase3_general_start_o,
   output logic general_start_out_o,
   output logic trip_out_o,
   // Current condition flags
   output logic phase1_current_ok_o,
   output logic phase2_current_ok_o,
   output logic phase3_current_ok_o,
   output logic residual_current_ok_o
);

   // Keeps a setting inside its documented range
   function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
      if (v < lo) begin
         clamp8 = lo;
      end else if (v > hi) begin
         clamp8 = hi;
      end else begin
         clamp8 = v;
      end
   endfunction

   // Current above percent of rated; products sized to 32 bits
   function automatic logic above_pct(input logic [15:0] cur, input logic [7:0] pct,
                                      input logic [15:0] rated);
      above_pct = (32'(cur) * `PERCENT_SCALE) > (32'(pct) * 32'(rated));
   endfunction

   selector_state_t state_reg; // Registered state
   selector_state_t state_next; // Next state
   logic blocked; // Off setting or block input
   logic earlier_active; // An earlier stage has claimed the fault
   logic [15:0] min_ground_impedance; // Least ground loop impedance
   logic [2:0] ground_loop_is_min; // Loop equals the minimum
   logic [2:0] in_zone; // Loop inside characteristic
   logic [2:0] phase_ok; // Per-phase sufficiency
   logic [2:0] cand; // Loops meeting every start condition except lockout and block
   logic [2:0] grant; // Starts after mutual exclusion
   logic [15:0] max_phase; // Largest phase current
   logic [7:0] imin_pct; // Clamped settings
   logic [7:0] base_pct;
   logic [7:0] bias_pct;
   logic [15:0] delay_ms; // Clamped trip delay
   logic [31:0] base_thr; // Residual thresholds, scaled by 100
   logic [31:0] bias_thr;
   logic run_timer; // Timer start condition

   // Decision logic and next state
   always_comb begin
      state_next = state_reg;
      blocked = operation_off_setting_i | block_input_i;
      imin_pct = clamp8(phase_current_min_setting_i, `IMIN_LO, `IMIN_HI); // R13
      base_pct = clamp8(residual_base_setting_i, `IRES_BASE_LO, `IRES_BASE_HI); // R14
      bias_pct = clamp8(residual_bias_setting_i, `IRES_BIAS_LO, `IRES_BIAS_HI); // R14
      // Delay beyond range is held at the maximum
      if (trip_delay_setting_i > `TRIP_DELAY_MAX_MS) begin
         delay_ms = `TRIP_DELAY_MAX_MS; // R16
      end else begin
         delay_ms = trip_delay_setting_i;
      end

      // Current condition unit
      state_next.phase_ok_1 = above_pct(phase1_current_i, imin_pct, RATED_CURRENT); // R12 R13
      state_next.phase_ok_2 = above_pct(phase2_current_i, imin_pct, RATED_CURRENT); // R13
      state_next.phase_ok_3 = above_pct(phase3_current_i, imin_pct, RATED_CURRENT); // R13
      max_phase = phase1_current_i;
      if (phase2_current_i > max_phase) begin
         max_phase = phase2_current_i;
      end
      if (phase3_current_i > max_phase) begin
         max_phase = phase3_current_i;
      end
      // Bias raises the residual threshold with heavy phase current
      base_thr = 32'(base_pct) * 32'(RATED_CURRENT);
      bias_thr = 32'(bias_pct) * 32'(max_phase); // R14
      if (bias_thr > base_thr) begin
         state_next.residual_ok = (32'(residual_current_i) * `PERCENT_SCALE) > bias_thr; // R17
      end else begin
         state_next.residual_ok = (32'(residual_current_i) * `PERCENT_SCALE) > base_thr; // R17
      end
      // Flags are one cycle old; the loop logic uses the registered copy
      phase_ok = {state_reg.phase_ok_3, state_reg.phase_ok_2, state_reg.phase_ok_1};

      // Minimum ground impedance
      min_ground_impedance = ground_loop1_impedance_i; // R03
      if (ground_loop2_impedance_i < min_ground_impedance) begin
         min_ground_impedance = ground_loop2_impedance_i; // R03
      end
      if (ground_loop3_impedance_i < min_ground_impedance) begin
         min_ground_impedance = ground_loop3_impedance_i; // R03
      end
      ground_loop_is_min[0] = ground_loop1_impedance_i == min_ground_impedance; // R03
      ground_loop_is_min[1] = ground_loop2_impedance_i == min_ground_impedance;
      ground_loop_is_min[2] = ground_loop3_impedance_i == min_ground_impedance;
      in_zone = {ground_loop3_in_zone_i, ground_loop2_in_zone_i, ground_loop1_in_zone_i};

      // Ground loop checks run only when no earlier stage holds
      earlier_active = three_phase_start_i | phase_loop12_start_i
                       | phase_loop23_start_i | phase_loop31_start_i;
      for (int k = 0; k < 3; k++) begin
         cand[k] = ~earlier_active // R01
                   & in_zone[k] & ground_loop_is_min[k] // R02 R07
                   & state_reg.residual_ok & phase_ok[k] // R05
                   & (min_ground_impedance < min_phase_pair_impedance_i); // R06
      end
      // A started loop locks out the others; equal minima favour lower phase
      grant[0] = cand[0] & ~state_reg.ground_start[1] & ~state_reg.ground_start[2]; // R04
      grant[1] = cand[1] & ~state_reg.ground_start[0] & ~state_reg.ground_start[2]
                 & ~grant[0]; // R04
      grant[2] = cand[2] & ~state_reg.ground_start[0] & ~state_reg.ground_start[1]
                 & ~grant[0] & ~grant[1]; // R04
      if (blocked) begin
         state_next.ground_start = 3'b000; // R08
      end else begin
         state_next.ground_start = grant;
      end

      // Phase involvement from every detected loop
      state_next.phase_start[0] = three_phase_start_i | phase_loop12_start_i
                                  | phase_loop31_start_i | grant[0]; // R09
      state_next.phase_start[1] = three_phase_start_i | phase_loop12_start_i
                                  | phase_loop23_start_i | grant[1]; // R09
      state_next.phase_start[2] = three_phase_start_i | phase_loop23_start_i
                                  | phase_loop31_start_i | grant[2]; // R09
      if (blocked) begin
         state_next.phase_start = 3'b000; // R08
      end
      state_next.phase_general = state_next.phase_start; // R09
      state_next.general_start = |state_next.phase_start; // R10

      // Trip timer counts whole milliseconds while the zone stays started
      run_timer = state_reg.general_start & ~start_only_setting_i & ~blocked; // R11 R15
      case (state_reg.tmr_state)
         TMR_IDLE: begin
            state_next.sub_count = 32'h0000_0000;
            state_next.ms_count = 16'h0000;
            state_next.trip = 1'b0;
            if (run_timer) begin
               state_next.tmr_state = TMR_TIMING; // R11
            end
         end
         TMR_TIMING: begin
            if (!run_timer) begin
               // Drop of start restarts the whole delay next time
               state_next.tmr_state = TMR_IDLE; // R18
               state_next.sub_count = 32'h0000_0000;
               state_next.ms_count = 16'h0000;
               state_next.trip = 1'b0; // R18
            end else if (state_reg.ms_count >= delay_ms) begin
               state_next.tmr_state = TMR_TRIPPED;
               state_next.trip = 1'b1; // R11 R16
            end else if (state_reg.sub_count == CYCLES_PER_MS - 32'h0000_0001) begin
               state_next.sub_count = 32'h0000_0000;
               state_next.ms_count = state_reg.ms_count + 16'h0001; // R16
            end else begin
               state_next.sub_count = state_reg.sub_count + 32'h0000_0001;
            end
         end
         TMR_TRIPPED: begin
            if (!run_timer) begin
               state_next.tmr_state = TMR_IDLE; // R18
               state_next.sub_count = 32'h0000_0000;
               state_next.ms_count = 16'h0000;
               state_next.trip = 1'b0; // R08 R18
            end
         end
         default: begin
            state_next.tmr_state = TMR_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg <= '0;
         state_reg.tmr_state <= TMR_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign ground_loop1_start_o = state_reg.ground_start[0];
   assign ground_loop2_start_o = state_reg.ground_start[1];
   assign ground_loop3_start_o = state_reg.ground_start[2];
   assign phase1_start_out_o = state_reg.phase_start[0];
   assign phase2_start_out_o = state_reg.phase_start[1];
   assign phase3_start_out_o = state_reg.phase_start[2];
   assign phase1_general_start_o = state_reg.phase_general[0];
   assign phase2_general_start_o = state_reg.phase_general[1];
   assign phase3_general_start_o = state_reg.phase_general[2];
   assign general_start_out_o = state_reg.general_start;
   assign trip_out_o = state_reg.trip;
   assign phase1_current_ok_o = state_reg.phase_ok_1;
   assign phase2_current_ok_o = state_reg.phase_ok_2;
   assign phase3_current_ok_o = state_reg.phase_ok_3;
   assign residual_current_ok_o = state_reg.residual_ok;

   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_earlier_blocks_ground: assert property ( // R01
      earlier_active |=> ~|state_reg.ground_start)
      else $error("ground start while earlier stage active");
   chk_start_needs_zone: assert property ( // R02
      ground_loop1_start_o |-> $past(ground_loop1_in_zone_i & ground_loop_is_min[0]))
      else $error("ground start without zone and minimum");
   chk_min_is_least: assert property ( // R03
      min_ground_impedance <= ground_loop1_impedance_i
      && min_ground_impedance <= ground_loop2_impedance_i
      && min_ground_impedance <= ground_loop3_impedance_i)
      else $error("minimum ground impedance not least");
   chk_one_ground_loop: assert property ( // R04
      $onehot0(state_reg.ground_start))
      else $error("two ground loops started");
   chk_start_needs_current: assert property ( // R05
      ground_loop2_start_o |-> $past(residual_current_ok_o & phase2_current_ok_o))
      else $error("ground start without current");
   chk_ground_below_pair: assert property ( // R06
      |state_reg.ground_start |-> $past(min_ground_impedance < min_phase_pair_impedance_i))
      else $error("ground start with larger ground minimum");
   chk_block_kills_all: assert property ( // R08
      blocked |=> !general_start_out_o && !trip_out_o && ~|state_reg.ground_start)
      else $error("output active while blocked");
   chk_general_any_phase: assert property ( // R10
      general_start_out_o == (phase1_start_out_o | phase2_start_out_o | phase3_start_out_o))
      else $error("general start mismatch");
   chk_ground_phase_follow: assert property ( // R09
      ground_loop3_start_o |-> phase3_start_out_o && phase3_general_start_o)
      else $error("phase start missing for ground loop");
   chk_start_only_no_trip: assert property ( // R15
      start_only_setting_i |=> !trip_out_o)
      else $error("trip while start only");
   chk_trip_drops: assert property ( // R18
      !general_start_out_o |=> !trip_out_o)
      else $error("trip held after start dropped");
   chk_zero_delay_trip: assert property ( // R11
      (state_reg.tmr_state == TMR_IDLE && run_timer && trip_delay_setting_i == 16'h0000)
      ##1 (run_timer && trip_delay_setting_i == 16'h0000) |=> trip_out_o)
      else $error("zero delay trip late");

   cov_ground_start: cover property (ground_loop1_start_o);
   cov_trip: cover property ($rose(trip_out_o));
   cov_blocked_start: cover property (blocked ##1 !general_start_out_o);
   cov_residual_bias: cover property (residual_current_ok_o && bias_thr > base_thr);

endmodule

// file: ground_fault_loop_selector_defs.svh
`ifndef GROUND_FAULT_LOOP_SELECTOR_DEFS_SVH
`define GROUND_FAULT_LOOP_SELECTOR_DEFS_SVH

// System clock rate and the millisecond time base
`define CLK_FREQ_HZ 32'h0131_2D00
`define MS_PER_S 32'h0000_03E8
`define CYCLES_PER_MS (`CLK_FREQ_HZ / `MS_PER_S)

// Phase minimum-current setting, percent of rated
`define IMIN_LO 8'h0A
`define IMIN_HI 8'h1E
`define IMIN_DEFAULT 8'h14

// Residual base sensitivity, percent of rated
`define IRES_BASE_LO 8'h0A
`define IRES_BASE_HI 8'h32
`define IRES_BASE_DEFAULT 8'h0A

// Residual bias slope, percent of largest phase current
`define IRES_BIAS_LO 8'h05
`define IRES_BIAS_HI 8'h1E
`define IRES_BIAS_DEFAULT 8'h0A

// Trip delay in milliseconds
`define TRIP_DELAY_MAX_MS 16'hEA60
`define TRIP_DELAY_DEFAULT_MS 16'h01F4

// Start-only default: trips are produced
`define START_ONLY_DEFAULT 1'b0

// Percent scale of the current comparisons
`define PERCENT_SCALE 32'h0000_0064

// Rated current expressed in current-input units
`define RATED_CURRENT_DEFAULT 16'h03E8

`endif

// file: ground_fault_loop_selector_pkg.sv
package ground_fault_loop_selector_pkg;
   // Trip delay timer states
   typedef enum logic [1:0] {
      TMR_IDLE,
      TMR_TIMING,
      TMR_TRIPPED
   } trip_timer_state_t;

   // Whole register state of the selector
   typedef struct packed {
      logic [2:0] ground_start;
      logic [2:0] phase_start;
      logic [2:0] phase_general;
      logic general_start;
      logic phase_ok_1;
      logic phase_ok_2;
      logic phase_ok_3;
      logic residual_ok;
      logic trip;
      trip_timer_state_t tmr_state;
      logic [31:0] sub_count;
      logic [15:0] ms_count;
   } selector_state_t;
endpackage

// file: loop_front_end.sv
`timescale 1ns/1ns
// Comparator and current front end; answers one edge after each command
module loop_front_end (
   // Clock
   input wire logic clk_sys_i,
   // Commands from the bench
   input wire logic [1:0] fault_phase_i,
   input wire logic tie_next_i,
   input wire logic pair_close_i,
   input wire logic [15:0] cur_level_i,
   input wire logic [15:0] res_level_i,
   input wire logic [1:0] weak_phase_i,
   // Loop comparators
   output logic [2:0] in_zone_o,
   output logic [15:0] z1_o,
   output logic [15:0] z2_o,
   output logic [15:0] z3_o,
   output logic [15:0] pair_min_o,
   // Current measurements; a weak phase carries no current
   output logic [15:0] cur1_o,
   output logic [15:0] cur2_o,
   output logic [15:0] cur3_o,
   output logic [15:0] res_o
);
   logic [2:0] hit; // Loops pulled inside the zone

   // Faulted loop lies lowest; a tie pulls the next loop down to the same value
   always_comb begin
      hit = (fault_phase_i == 2'h0) ? 3'h0 : 3'(1 << (fault_phase_i - 2'h1));
      if (tie_next_i) begin
         hit = hit | {hit[1:0], hit[2]};
      end
   end

   // Registered answers, one edge after each command
   always_ff @(posedge clk_sys_i) begin
      in_zone_o <= hit;
      z1_o <= hit[0] ? 16'h0064 : 16'h0190;
      z2_o <= hit[1] ? 16'h0064 : 16'h0190;
      z3_o <= hit[2] ? 16'h0064 : 16'h0190;
      // Close pair minimum equals the ground minimum, so strict less fails
      pair_min_o <= pair_close_i ? 16'h0064 : 16'h012C;
      cur1_o <= (weak_phase_i == 2'h1) ? 16'h0000 : cur_level_i;
      cur2_o <= (weak_phase_i == 2'h2) ? 16'h0000 : cur_level_i;
      cur3_o <= (weak_phase_i == 2'h3) ? 16'h0000 : cur_level_i;
      res_o <= res_level_i;
   end
endmodule

// file: test_ground_fault_loop_selector.sv
`timescale 1ns/1ns
module test_ground_fault_loop_selector;
   import ground_fault_loop_selector_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   // Earlier stages, settings and front end commands
   logic tp = 1'b0;
   logic [2:0] pl = 3'h0;
   logic off = 1'b0;
   logic blk = 1'b0;
   logic so = 1'b0;
   logic [15:0] dly = 16'h0000;
   logic [1:0] fp = 2'h0;
   logic tie = 1'b0;
   logic pc = 1'b0;
   logic [15:0] cl = 16'h01F4;
   logic [15:0] rl = 16'h012C;
   logic [1:0] wk = 2'h0;
   logic [7:0] imin = 8'h14;
   // Front end answers and design outputs
   logic [2:0] zn;
   logic [15:0] z1, z2, z3, zp, cur1, cur2, cur3, res;
   logic [2:0] gs, ps, pg, cok;
   logic gen, trip, rok;
   int failures = 0;
   int cmp_count = 0;

   // Free-running system clock, 50 ns period
   always #25 clk_sys_i = ~clk_sys_i;

   loop_front_end i_loop_front_end (.clk_sys_i(clk_sys_i), .fault_phase_i(fp),
      .tie_next_i(tie), .pair_close_i(pc), .cur_level_i(cl), .res_level_i(rl),
      .weak_phase_i(wk), .in_zone_o(zn), .z1_o(z1), .z2_o(z2), .z3_o(z3),
      .pair_min_o(zp), .cur1_o(cur1), .cur2_o(cur2), .cur3_o(cur3), .res_o(res));

   // Short millisecond of 4 cycles keeps the trip delays to about ten cycles
   // Base setting below its range must act as 10 percent
   ground_fault_loop_selector #(.CYCLES_PER_MS(32'h0000_0004)) i_ground_fault_loop_selector (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .three_phase_start_i(tp),
      .phase_loop12_start_i(pl[0]), .phase_loop23_start_i(pl[1]),
      .phase_loop31_start_i(pl[2]), .ground_loop1_in_zone_i(zn[0]),
      .ground_loop2_in_zone_i(zn[1]), .ground_loop3_in_zone_i(zn[2]),
      .ground_loop1_impedance_i(z1), .ground_loop2_impedance_i(z2),
      .ground_loop3_impedance_i(z3), .min_phase_pair_impedance_i(zp),
      .phase1_current_i(cur1), .phase2_current_i(cur2), .phase3_current_i(cur3),
      .residual_current_i(res), .operation_off_setting_i(off), .block_input_i(blk),
      .start_only_setting_i(so), .trip_delay_setting_i(dly),
      .phase_current_min_setting_i(imin), .residual_base_setting_i(8'h00),
      .residual_bias_setting_i(8'h0A), .ground_loop1_start_o(gs[0]),
      .ground_loop2_start_o(gs[1]), .ground_loop3_start_o(gs[2]),
      .phase1_start_out_o(ps[0]), .phase2_start_out_o(ps[1]), .phase3_start_out_o(ps[2]),
      .phase1_general_start_o(pg[0]), .phase2_general_start_o(pg[1]),
      .phase3_general_start_o(pg[2]), .general_start_out_o(gen), .trip_out_o(trip),
      .phase1_current_ok_o(cok[0]), .phase2_current_ok_o(cok[1]),
      .phase3_current_ok_o(cok[2]), .residual_current_ok_o(rok));

   // Let n edges pass, then step past the updates of the last one
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // Counted case-equality compare
   task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   // Ground starts, phase starts and the general start together
   task automatic chk_st(input logic [2:0] g, input logic [2:0] p);
      chk(gs, g, "ground start");
      chk(ps, p, "phase start");
      chk(pg, p, "phase general start");
      chk({2'h0, gen}, {2'h0, |p}, "general start");
   endtask

   // Each loop alone, least and inside the zone
   task automatic t_loops;
      for (int p = 0; p < 3; p++) begin
         @(posedge clk_sys_i) fp <= 2'(p + 1);
         wt(5);
         chk_st(3'(1 << p), 3'(1 << p));
         chk(cok, 3'h7, "phase current flags");
         chk({2'h0, rok}, 3'h1, "residual flag");
      end
      @(posedge clk_sys_i) fp <= 2'h0;
      wt(5);
      chk_st(3'h0, 3'h0);
      $display("loops test done");
   endtask

   // Earlier stages win over a ground fault and set their own phases
   task automatic t_prior;
      logic [2:0] exp [4];
      exp = '{3'h7, 3'h3, 3'h6, 3'h5};
      @(posedge clk_sys_i) fp <= 2'h1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_i) tp <= (k == 0);
         pl <= (k == 0) ? 3'h0 : 3'(1 << (k - 1));
         wt(5);
         chk_st(3'h0, exp[k]);
      end
      @(posedge clk_sys_i) pl <= 3'h0;
      wt(5);
      chk_st(3'h1, 3'h1);
      $display("priority test done");
   endtask

   // Current flags at their thresholds gate the ground start
   task automatic t_current;
      @(posedge clk_sys_i) cl <= 16'h00C8;
      wt(5);
      chk(cok, 3'h0, "current at threshold");
      chk(gs, 3'h0, "start without current");
      @(posedge clk_sys_i) cl <= 16'h00C9;
      wt(5);
      chk(cok, 3'h7, "current above threshold");
      chk(gs, 3'h1, "start with current");
      @(posedge clk_sys_i) wk <= 2'h1;
      wt(5);
      chk(cok, 3'h6, "phase one weak");
      chk(gs, 3'h0, "start with own phase weak");
      @(posedge clk_sys_i) wk <= 2'h2;
      wt(5);
      chk(cok, 3'h5, "phase two weak");
      chk(gs, 3'h1, "start with other phase weak");
      @(posedge clk_sys_i) wk <= 2'h0;
      imin <= 8'hFF;
      cl <= 16'h012D;
      wt(5);
      chk(cok, 3'h7, "setting held at 30 percent");
      @(posedge clk_sys_i) imin <= 8'h00;
      cl <= 16'h0064;
      wt(5);
      chk(cok, 3'h0, "setting held at 10 percent");
      @(posedge clk_sys_i) imin <= 8'h14;
      @(posedge clk_sys_i) cl <= 16'h07D0;
      rl <= 16'h0096;
      wt(5);
      chk({2'h0, rok}, 3'h0, "residual under bias");
      chk(gs, 3'h0, "start without residual");
      @(posedge clk_sys_i) rl <= 16'h00C9;
      wt(5);
      chk({2'h0, rok}, 3'h1, "residual over bias");
      @(posedge clk_sys_i) cl <= 16'h01F4;
      rl <= 16'h0064;
      wt(5);
      chk({2'h0, rok}, 3'h0, "residual at base");
      @(posedge clk_sys_i) rl <= 16'h012C;
      $display("current test done");
   endtask

   // Equal pair minimum, and a second equal loop while one has started
   task automatic t_minimum;
      @(posedge clk_sys_i) pc <= 1'b1;
      wt(5);
      chk_st(3'h0, 3'h0);
      @(posedge clk_sys_i) pc <= 1'b0;
      wt(5);
      @(posedge clk_sys_i) tie <= 1'b1;
      wt(6);
      chk_st(3'h1, 3'h1);
      @(posedge clk_sys_i) tie <= 1'b0;
      $display("minimum test done");
   endtask

   // Off setting and block input silence starts and a zero-delay trip
   task automatic t_block;
      @(posedge clk_sys_i) dly <= 16'h0000;
      wt(8);
      chk({2'h0, trip}, 3'h1, "zero delay trip");
      @(posedge clk_sys_i) off <= 1'b1;
      wt(3);
      chk_st(3'h0, 3'h0);
      chk({2'h0, trip}, 3'h0, "trip while off");
      @(posedge clk_sys_i) off <= 1'b0;
      blk <= 1'b1;
      wt(3);
      chk_st(3'h0, 3'h0);
      chk({2'h0, trip}, 3'h0, "trip while blocked");
      @(posedge clk_sys_i) blk <= 1'b0;
      fp <= 2'h0;
      wt(4);
      $display("block test done");
   endtask

   // Start a fault and time the trip against a 2 ms delay
   task automatic timed_start;
      int n;
      n = 0;
      @(posedge clk_sys_i) fp <= 2'h1;
      wt(1);
      while (gen !== 1'b1 && n < 10) begin
         wt(1);
         n++;
      end
      // Timer starts one edge after the start; 2 ms of 4 cycles plus two
      wt(9);
      chk({2'h0, trip}, 3'h0, "trip too early");
      wt(1);
      chk({2'h0, trip}, 3'h1, "trip missing");
   endtask

   // Delay, start-only and restart of the full delay
   task automatic t_trip;
      @(posedge clk_sys_i) dly <= 16'h0002;
      timed_start();
      @(posedge clk_sys_i) so <= 1'b1;
      wt(3);
      chk({2'h0, trip}, 3'h0, "trip in start-only");
      @(posedge clk_sys_i) so <= 1'b0;
      fp <= 2'h0;
      wt(4);
      chk({2'h0, trip}, 3'h0, "trip after fault gone");
      timed_start();
      @(posedge clk_sys_i) fp <= 2'h0;
      wt(4);
      $display("trip test done");
   endtask

   // Counts, verdict and end of run
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_loops();
      t_prior();
      t_current();
      t_minimum();
      t_block();
      t_trip();
      finish_test();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      failures++;
      finish_test();
   end
endmodule
